/* File: pkg/mmu_defs.vh */
`ifndef MMU_DEFS_VH
`define MMU_DEFS_VH

// ****************
// register offsets (byte addresses)
// ****************
`define MMU_OFF_CTRL   8'h00
`define MMU_OFF_TAG    8'h04
`define MMU_OFF_DOMAIN 8'h08
`define MMU_OFF_TBASE  8'h0C
`define MMU_OFF_LOCK   8'h10
`define MMU_OFF_STATUS 8'h14
`define MMU_OFF_FVA    8'h18
`define MMU_OFF_FLUSH  8'h1C

// ****************
// control and status fields
// ****************
`define MMU_CTRL_EN     0
`define MMU_CTRL_LEGACY 1
`define MMU_LOCK_VICT   2:0
`define MMU_LOCK_FILL   3
`define MMU_FLUSH_MAIN  0
`define MMU_FLUSH_LOCK  1

// abort causes
`define MMU_C_NONE  2'h0
`define MMU_C_XLAT  2'h1
`define MMU_C_DOM   2'h2
`define MMU_C_PERM  2'h3

// page sizes: 4KB, 64KB, 1MB, 16MB
`define MMU_SZ_4K   2'h0
`define MMU_SZ_64K  2'h1
`define MMU_SZ_1M   2'h2
`define MMU_SZ_16M  2'h3

// domain control codes
`define MMU_D_CLIENT  2'h1
`define MMU_D_MANAGER 2'h3

// ****************
// tlb entry layout
// ****************
`define MMU_EW    72
`define MMU_E_V   0
`define MMU_E_SZ  2:1
`define MMU_E_VT  22:3
`define MMU_E_PT  42:23
`define MMU_E_AS  50:43
`define MMU_E_G   51
`define MMU_E_DOM 55:52
`define MMU_E_AP  67:56
`define MMU_E_AP_LO 56
`define MMU_AP_W  3
`define MMU_E_MT  70:68
`define MMU_E_SH  71

`endif

/* File: rtl/mmu_top.v */
// Summary of operation
// - maps 4KB, 64KB, 1MB and 16MB pages
// - sections share one permission setting
// - pages carry permission per quarter subpage
// - 2x32 two-way TLB plus eight locked
// - only global or current-tag entries usable outside legacy mode
// - no-access, read-only, read/write by mode, domain
// - failed permission blocks access, signals abort
// - privileged-only and all read-only coexist outside legacy mode
// - miss triggers hardware table walk
// - walk result written into TLB
// - one table set serves both ports
// - one control bit enables both paths
// - locked entries never replaced
// - legacy mode drops address tags
// - entries carry memory type, forwarded out
// - entries carry shared attribute
// - translates and checks instruction and data ports
// - current address tag is eight bits
// - hit on VA[31:N] and tag or global
// - round-robin replacement in main TLB
`timescale 1ns/1ps
`include "mmu_defs.vh"

module mmu_top #(
   parameter NMAIN = 64,
   parameter NLOCK = 8
) (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire        i_req,
   input  wire [31:0] i_va,
   input  wire        i_user,
   output reg         i_ack,
   input  wire        d_req,
   input  wire [31:0] d_va,
   input  wire        d_write,
   input  wire        d_user,
   output reg         d_ack,
   output reg  [31:0] rsp_pa,
   output reg         rsp_abort,
   output reg  [2:0]  rsp_mem_type,
   output reg         rsp_shared,
   output reg         mem_req,
   output reg  [31:0] mem_addr,
   input  wire [31:0] mem_rdata,
   input  wire        mem_ack
);

   localparam NENT = NMAIN + NLOCK;
   localparam [2:0] S_IDLE = 3'h0;
   localparam [2:0] S_LOOK = 3'h1;
   localparam [2:0] S_L1RQ = 3'h2;
   localparam [2:0] S_L1WT = 3'h3;
   localparam [2:0] S_L2RQ = 3'h4;
   localparam [2:0] S_L2WT = 3'h5;
   localparam [2:0] S_FILL = 3'h6;
   localparam [2:0] S_DONE = 3'h7;

   // ****************
   // registers
   // ****************
   reg  [1:0]         ctrl_r;
   reg  [7:0]         address_space_tag_r;
   reg  [31:0]        domain_r;
   reg  [31:0]        tbase_r;
   reg  [3:0]         lock_r;
   reg  [1:0]         cause_r;
   reg  [15:0]        walks_r;
   reg  [31:0]        fva_r;
   reg  [2:0]         state_r;
   reg  [31:0]        va_r;
   reg                wr_r;
   reg                user_r;
   reg                side_r;
   reg  [31:0]        l1_r;
   reg  [`MMU_EW-1:0] new_r;
   reg                rr_r;
   reg  [`MMU_EW-1:0] ent_r [0:NENT-1];
   reg  [31:0]        rd_mux;
   reg                rd_ok;
   reg  [`MMU_EW-1:0] hit_ent;
   reg  [2:0]         ap_sel;
   reg  [31:0]        pa_c;
   reg                perm_ok;
   reg  [1:0]         dctl;
   reg  [1:0]         quarter;
   reg  [6:0]         slot;
   wire [NENT-1:0]    hit;
   wire               any_hit;
   wire               apb_wr;
   wire               legacy;
   integer            k;
   integer            m;

   assign legacy  = ctrl_r[`MMU_CTRL_LEGACY];
   assign any_hit = |hit;
   assign apb_wr  = psel & penable & pwrite & rd_ok;

   // ****************
   // lookup over all entries
   // ****************
   genvar g;
   generate
      for (g = 0; g < NENT; g = g + 1) begin : g_cmp
         wire [`MMU_EW-1:0] e = ent_r[g];
         wire [1:0]         sz = e[`MMU_E_SZ];
         wire [19:0]        vt = e[`MMU_E_VT];
         wire va_eq = (vt[19:12] == va_r[31:24]) &&
                      (sz == `MMU_SZ_16M || vt[11:8] == va_r[23:20]) &&
                      (sz[1] || vt[7:4] == va_r[19:16]) &&
                      (sz != `MMU_SZ_4K || vt[3:0] == va_r[15:12]);
         // global or tag match; legacy ignores tags
         wire tag_eq = e[`MMU_E_G] | legacy | (e[`MMU_E_AS] == address_space_tag_r);
         assign hit[g] = e[`MMU_E_V] & va_eq & tag_eq;
      end
   endgenerate

   always @* begin
      hit_ent = {`MMU_EW{1'b0}};
      for (k = 0; k < NENT; k = k + 1) begin
         hit_ent = hit_ent | ({`MMU_EW{hit[k]}} & ent_r[k]);
      end
      quarter = (hit_ent[`MMU_E_SZ] == `MMU_SZ_4K) ? va_r[11:10] : va_r[15:14];
      ap_sel  = hit_ent[`MMU_E_AP_LO + `MMU_AP_W * quarter +: `MMU_AP_W];
      if (legacy) begin
         ap_sel[2] = 1'b0;
      end
      case (hit_ent[`MMU_E_SZ])
         `MMU_SZ_4K:  pa_c = {hit_ent[42:23], va_r[11:0]};
         `MMU_SZ_64K: pa_c = {hit_ent[42:27], va_r[15:0]};
         `MMU_SZ_1M:  pa_c = {hit_ent[42:31], va_r[19:0]};
         default:     pa_c = {hit_ent[42:35], va_r[23:0]};
      endcase
      case (ap_sel)
         3'h1:    perm_ok = ~user_r;
         3'h2:    perm_ok = ~user_r | ~wr_r;
         3'h3:    perm_ok = 1'b1;
         3'h5:    perm_ok = ~user_r & ~wr_r;
         3'h6:    perm_ok = ~wr_r;
         3'h7:    perm_ok = ~wr_r;
         default: perm_ok = 1'b0;
      endcase
      dctl = domain_r[{hit_ent[`MMU_E_DOM], 1'b0} +: 2];
      if (lock_r[`MMU_LOCK_FILL]) begin
         slot = NMAIN[6:0] + {4'h0, lock_r[`MMU_LOCK_VICT]};
      end else begin
         slot = {1'b0, rr_r, va_r[16:12]};
      end
   end

   // ****************
   // apb slave
   // ****************
   always @* begin
      rd_ok = 1'b1;
      case (paddr)
         `MMU_OFF_CTRL:   rd_mux = {30'h0, ctrl_r};
         `MMU_OFF_TAG:    rd_mux = {24'h0, address_space_tag_r};
         `MMU_OFF_DOMAIN: rd_mux = domain_r;
         `MMU_OFF_TBASE:  rd_mux = tbase_r;
         `MMU_OFF_LOCK:   rd_mux = {28'h0, lock_r};
         `MMU_OFF_STATUS: rd_mux = {walks_r, 11'h0, state_r, cause_r};
         `MMU_OFF_FVA:    rd_mux = fva_r;
         `MMU_OFF_FLUSH:  rd_mux = 32'h0;
         default: begin
            rd_mux = 32'h0;
            rd_ok  = 1'b0;
         end
      endcase
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata              <= 32'h0;
         pready              <= 1'b0;
         pslverr             <= 1'b0;
         ctrl_r              <= 2'h0;
         address_space_tag_r <= 8'h00;
         domain_r            <= 32'h0;
         tbase_r             <= 32'h0;
         lock_r              <= 4'h0;
      end else begin
         pready <= 1'b1;
         if (psel && !penable) begin
            prdata  <= rd_mux;
            pslverr <= ~rd_ok;
         end
         if (apb_wr) begin
            case (paddr)
               `MMU_OFF_CTRL:   ctrl_r <= pwdata[1:0];
               `MMU_OFF_TAG:    address_space_tag_r <= pwdata[7:0];
               `MMU_OFF_DOMAIN: domain_r <= pwdata;
               `MMU_OFF_TBASE:  tbase_r <= {pwdata[31:14], 14'h0};
               `MMU_OFF_LOCK:   lock_r <= pwdata[3:0];
               default:         lock_r <= lock_r;
            endcase
         end
      end
   end

   // ****************
   // request, walk and fill sequencer
   // ****************
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r      <= S_IDLE;
         va_r         <= 32'h0;
         wr_r         <= 1'b0;
         user_r       <= 1'b0;
         side_r       <= 1'b0;
         l1_r         <= 32'h0;
         new_r        <= {`MMU_EW{1'b0}};
         rr_r         <= 1'b0;
         cause_r      <= `MMU_C_NONE;
         walks_r      <= 16'h0;
         fva_r        <= 32'h0;
         i_ack        <= 1'b0;
         d_ack        <= 1'b0;
         rsp_pa       <= 32'h0;
         rsp_abort    <= 1'b0;
         rsp_mem_type <= 3'h0;
         rsp_shared   <= 1'b0;
         mem_req      <= 1'b0;
         mem_addr     <= 32'h0;
         for (m = 0; m < NENT; m = m + 1) begin
            ent_r[m] <= {`MMU_EW{1'b0}};
         end
      end else begin
         i_ack <= 1'b0;
         d_ack <= 1'b0;
         if (apb_wr && paddr == `MMU_OFF_FLUSH) begin
            for (m = 0; m < NENT; m = m + 1) begin
               if ((m < NMAIN) ? pwdata[`MMU_FLUSH_MAIN] : pwdata[`MMU_FLUSH_LOCK]) begin
                  ent_r[m] <= {`MMU_EW{1'b0}};
               end
            end
         end
         case (state_r)
            S_IDLE: begin
               // data port first, then instruction port
               if (d_req) begin
                  va_r    <= d_va;
                  wr_r    <= d_write;
                  user_r  <= d_user;
                  side_r  <= 1'b1;
                  state_r <= S_LOOK;
               end else if (i_req) begin
                  va_r    <= i_va;
                  wr_r    <= 1'b0;
                  user_r  <= i_user;
                  side_r  <= 1'b0;
                  state_r <= S_LOOK;
               end
            end
            S_LOOK: begin
               if (!ctrl_r[`MMU_CTRL_EN] || any_hit) begin
                  i_ack   <= ~side_r;
                  d_ack   <= side_r;
                  state_r <= S_DONE;
               end else begin
                  state_r <= S_L1RQ;
               end
               if (!ctrl_r[`MMU_CTRL_EN]) begin
                  rsp_pa       <= va_r;
                  rsp_abort    <= 1'b0;
                  rsp_mem_type <= 3'h0;
                  rsp_shared   <= 1'b0;
               end else if (any_hit) begin
                  rsp_pa       <= pa_c;
                  rsp_mem_type <= hit_ent[`MMU_E_MT];
                  rsp_shared   <= hit_ent[`MMU_E_SH];
                  if (dctl == `MMU_D_MANAGER) begin
                     rsp_abort <= 1'b0;
                  end else if (dctl != `MMU_D_CLIENT) begin
                     rsp_abort <= 1'b1;
                     cause_r   <= `MMU_C_DOM;
                     fva_r     <= va_r;
                  end else begin
                     rsp_abort <= ~perm_ok;
                     if (!perm_ok) begin
                        cause_r <= `MMU_C_PERM;
                        fva_r   <= va_r;
                     end
                  end
               end
            end
            S_L1RQ: begin
               // walk of the shared first-level table
               mem_req  <= 1'b1;
               mem_addr <= {tbase_r[31:14], va_r[31:20], 2'h0};
               walks_r  <= walks_r + 16'h1;
               state_r  <= S_L1WT;
            end
            S_L1WT: begin
               if (mem_ack) begin
                  mem_req <= 1'b0;
                  l1_r    <= mem_rdata;
                  new_r[`MMU_E_V]  <= 1'b1;
                  new_r[`MMU_E_VT] <= va_r[31:12];
                  new_r[`MMU_E_AS] <= address_space_tag_r;
                  // one setting copied to all quarters
                  new_r[`MMU_E_AP] <= {4{mem_rdata[15], mem_rdata[11:10]}};
                  new_r[`MMU_E_MT] <= {mem_rdata[12], mem_rdata[3:2]};
                  new_r[`MMU_E_SH] <= mem_rdata[16];
                  new_r[`MMU_E_G]  <= ~mem_rdata[17];
                  if (mem_rdata[1:0] == 2'h2 && mem_rdata[18]) begin
                     new_r[`MMU_E_SZ]  <= `MMU_SZ_16M;
                     new_r[`MMU_E_PT]  <= {mem_rdata[31:24], 12'h000};
                     new_r[`MMU_E_DOM] <= 4'h0;
                     state_r           <= S_FILL;
                  end else if (mem_rdata[1:0] == 2'h2) begin
                     new_r[`MMU_E_SZ]  <= `MMU_SZ_1M;
                     new_r[`MMU_E_PT]  <= {mem_rdata[31:20], 8'h00};
                     new_r[`MMU_E_DOM] <= mem_rdata[8:5];
                     state_r           <= S_FILL;
                  end else if (mem_rdata[1:0] == 2'h1) begin
                     state_r <= S_L2RQ;
                  end else begin
                     rsp_pa    <= va_r;
                     rsp_abort <= 1'b1;
                     cause_r   <= `MMU_C_XLAT;
                     fva_r     <= va_r;
                     i_ack     <= ~side_r;
                     d_ack     <= side_r;
                     state_r   <= S_DONE;
                  end
               end
            end
            S_L2RQ: begin
               mem_req  <= 1'b1;
               mem_addr <= {l1_r[31:10], va_r[19:12], 2'h0};
               state_r  <= S_L2WT;
            end
            S_L2WT: begin
               if (mem_ack) begin
                  mem_req <= 1'b0;
                  new_r[`MMU_E_AP]  <= {l1_r[3], mem_rdata[11:10], l1_r[3], mem_rdata[9:8],
                                        l1_r[3], mem_rdata[7:6], l1_r[3], mem_rdata[5:4]};
                  new_r[`MMU_E_MT]  <= {1'b0, mem_rdata[3:2]};
                  new_r[`MMU_E_SH]  <= l1_r[4];
                  new_r[`MMU_E_G]   <= ~l1_r[2];
                  new_r[`MMU_E_DOM] <= l1_r[8:5];
                  if (mem_rdata[1]) begin
                     new_r[`MMU_E_SZ] <= `MMU_SZ_4K;
                     new_r[`MMU_E_PT] <= mem_rdata[31:12];
                     state_r          <= S_FILL;
                  end else if (mem_rdata[0]) begin
                     new_r[`MMU_E_SZ] <= `MMU_SZ_64K;
                     new_r[`MMU_E_PT] <= {mem_rdata[31:16], 4'h0};
                     state_r          <= S_FILL;
                  end else begin
                     rsp_pa    <= va_r;
                     rsp_abort <= 1'b1;
                     cause_r   <= `MMU_C_XLAT;
                     fva_r     <= va_r;
                     i_ack     <= ~side_r;
                     d_ack     <= side_r;
                     state_r   <= S_DONE;
                  end
               end
            end
            S_FILL: begin
               // store into main ways or lockdown slot
               ent_r[slot] <= new_r;
               if (!lock_r[`MMU_LOCK_FILL]) begin
                  rr_r <= ~rr_r;
               end
               state_r <= S_LOOK;
            end
            S_DONE: begin
               state_r <= S_IDLE;
            end
            default: begin
               state_r <= S_IDLE;
            end
         endcase
      end
   end

endmodule

/* File: tb/mmu_top_asserts.sv */
`timescale 1ns/1ps
module mmu_chk #(
   parameter NMAIN = 64,
   parameter NLOCK = 8
) (
   input wire        pclk,
   input wire        presetn,
   input wire        psel,
   input wire        penable,
   input wire [7:0]  paddr,
   input wire        pready,
   input wire        pslverr,
   input wire        i_req,
   input wire        i_ack,
   input wire        d_req,
   input wire        d_ack,
   input wire [31:0] rsp_pa,
   input wire        rsp_abort,
   input wire        mem_req,
   input wire [31:0] mem_addr,
   input wire        mem_ack
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ****************
   // bus and port relations
   // ****************
   property p_rdy; psel && penable |-> pready; endproperty
   a_rdy: assert property (p_rdy) else $error("access phase without ready");
   property p_err; psel && penable |-> pslverr == (paddr > 8'h1C || paddr[1:0] != 2'h0);
   endproperty
   a_err: assert property (p_err) else $error("error flag wrong for offset");
   property p_pulse; (i_ack || d_ack) |=> !(i_ack || d_ack); endproperty
   a_pulse: assert property (p_pulse) else $error("ack longer than one cycle");
   property p_excl; !(i_ack && d_ack); endproperty
   a_excl: assert property (p_excl) else $error("both ports acked together");
   property p_ackreq; (i_ack |-> i_req) and (d_ack |-> d_req); endproperty
   a_ackreq: assert property (p_ackreq) else $error("ack without request");
   property p_dlat; $rose(d_req) |-> ##[2:200] d_ack; endproperty
   a_dlat: assert property (p_dlat) else $error("data request not answered");
   property p_walk; mem_req |-> (i_req || d_req); endproperty
   a_walk: assert property (p_walk) else $error("table read without request");
   property p_mhold; mem_req && !mem_ack |=> mem_req && $stable(mem_addr); endproperty
   a_mhold: assert property (p_mhold) else $error("table read dropped early");
   property p_malign; mem_req |-> mem_addr[1:0] == 2'h0; endproperty
   a_malign: assert property (p_malign) else $error("descriptor address unaligned");
   property p_rsp; $changed(rsp_pa) |-> (i_ack || d_ack); endproperty
   a_rsp: assert property (p_rsp) else $error("response changed without ack");
   property p_ackidle; (i_ack || d_ack) |-> !mem_req; endproperty
   a_ackidle: assert property (p_ackidle) else $error("ack during table read");
   c_hit: cover property (d_ack && !rsp_abort);
   c_abort: cover property ((i_ack || d_ack) && rsp_abort);
   c_walk: cover property (mem_ack);
   c_err: cover property (penable && pslverr);
endmodule

bind mmu_top mmu_chk #(
   .NMAIN(NMAIN),
   .NLOCK(NLOCK)
) mmu_chk_inst (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
   .pready(pready), .pslverr(pslverr), .i_req(i_req), .i_ack(i_ack), .d_req(d_req),
   .d_ack(d_ack), .rsp_pa(rsp_pa), .rsp_abort(rsp_abort), .mem_req(mem_req),
   .mem_addr(mem_addr), .mem_ack(mem_ack)
);

/* File: tb/mmu_mem_model.sv */
`timescale 1ns/1ps
module mmu_mem_model (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        slow,
   input  wire        mem_req,
   input  wire [31:0] mem_addr,
   output reg  [31:0] mem_rdata,
   output reg         mem_ack
);
   reg [31:0] mem [0:8191];
   reg [1:0]  cnt_r;
   integer    k;
   initial begin
      for (k = 0; k < 8192; k = k + 1) mem[k] = 32'h00000000;
   end
   // idle data toggles so stale values never look valid
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mem_ack <= 1'b0;
         cnt_r <= 2'h0;
         mem_rdata <= 32'h00000000;
      end else if (mem_ack || !mem_req) begin
         mem_ack <= 1'b0;
         cnt_r <= 2'h0;
         mem_rdata <= ~mem_rdata;
      end else if (cnt_r == (slow ? 2'h3 : 2'h0)) begin
         mem_ack <= 1'b1;
         mem_rdata <= mem[mem_addr[14:2]];
      end else begin
         cnt_r <= cnt_r + 2'h1;
      end
   end
endmodule

/* File: tb/tb_mmu_address_translation.sv */
`timescale 1ns/1ps
`include "mmu_defs.vh"
module tb_mmu_address_translation;
   reg         pclk, presetn, psel, penable, pwrite, i_req, i_user, d_req, d_write, d_user;
   reg         slow, er, r_ab, r_sh, dp;
   reg  [7:0]  paddr, apq;
   reg  [2:0]  r_mt;
   reg  [1:0]  sz;
   reg  [31:0] pwdata, i_va, d_va, rd, r_pa, va, pa, pb;
   wire [31:0] prdata, rsp_pa, mem_addr, mem_rdata;
   wire [2:0]  rsp_mem_type;
   wire        pready, pslverr, i_ack, d_ack, rsp_abort, rsp_shared, mem_req, mem_ack;
   integer     n_errors, checked, seed, ew, i, j;

   mmu_top #(.NMAIN(64), .NLOCK(8)) mmu_top_inst (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .i_req(i_req), .i_va(i_va), .i_user(i_user), .i_ack(i_ack), .d_req(d_req),
      .d_va(d_va), .d_write(d_write), .d_user(d_user), .d_ack(d_ack), .rsp_pa(rsp_pa),
      .rsp_abort(rsp_abort), .rsp_mem_type(rsp_mem_type), .rsp_shared(rsp_shared),
      .mem_req(mem_req), .mem_addr(mem_addr), .mem_rdata(mem_rdata), .mem_ack(mem_ack)
   );
   mmu_mem_model mmu_mem_model_inst (
      .pclk(pclk), .presetn(presetn), .slow(slow), .mem_req(mem_req),
      .mem_addr(mem_addr), .mem_rdata(mem_rdata), .mem_ack(mem_ack)
   );

   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   initial begin
      #100000;
      n_errors = n_errors + 1;
      tally_and_finish;
   end

   // ****************
   // helpers
   // ****************
   task tally_and_finish;
      begin
         if (n_errors == 0 && checked > 0)
            $display("Result: passed");
         else
            $display("Result: failed");
         $finish;
      end
   endtask
   task chk(input [63:0] nm, input [31:0] e, input [31:0] g);
      begin
         checked = checked + 1;
         if (g !== e) begin
            n_errors = n_errors + 1;
            $display("[ERR] %s exp %h got %h", nm, e, g);
         end
      end
   endtask
   task chk_rsp(input ea, input [31:0] ep, input [2:0] em, input es);
      begin
         chk("abort", {31'h0, ea}, {31'h0, r_ab});
         if (ea === 1'b0) begin
            chk("pa", ep, r_pa);
            chk("memtype", {29'h0, em}, {29'h0, r_mt});
            chk("shared", {31'h0, es}, {31'h0, r_sh});
         end
      end
   endtask
   task apb(input wr, input [7:0] a, input [31:0] wd);
      begin
         @(posedge pclk);
         psel <= 1'b1;
         pwrite <= wr;
         paddr <= a;
         pwdata <= wd;
         @(posedge pclk);
         penable <= 1'b1;
         do @(posedge pclk); while (pready !== 1'b1);
         rd = prdata;
         er = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         pwdata <= ~wd;
      end
   endtask
   task xl(input p, input [31:0] v, input wr, input us);
      begin
         @(posedge pclk);
         slow <= $random(seed);
         i_va <= v;
         d_va <= v;
         d_write <= wr;
         i_user <= us;
         d_user <= us;
         i_req <= !p;
         d_req <= p;
         do @(posedge pclk); while ((p ? d_ack : i_ack) !== 1'b1);
         r_pa = rsp_pa;
         r_ab = rsp_abort;
         r_mt = rsp_mem_type;
         r_sh = rsp_shared;
         i_req <= 1'b0;
         d_req <= 1'b0;
         i_va <= ~v;
         d_va <= ~v;
      end
   endtask
   task walks_is(input integer e);
      begin
         apb(1'b0, `MMU_OFF_STATUS, 32'h0);
         chk("walks", e, {16'h0, rd[31:16]});
      end
   endtask
   task cause_is(input [1:0] c, input [31:0] v);
      begin
         apb(1'b0, `MMU_OFF_STATUS, 32'h0);
         chk("cause", {30'h0, c}, {30'h0, rd[1:0]});
         apb(1'b0, `MMU_OFF_FVA, 32'h0);
         chk("fva", v, rd);
      end
   endtask
   task put(input [12:0] ix, input [31:0] d);
      mmu_mem_model_inst.mem[ix] = d;
   endtask
   function [31:0] sec(input [11:0] hi, input apx, input [1:0] ap, input ng, input s,
                       input [2:0] t);
      sec = {hi, 2'h0, ng, s, apx, 2'h0, t[2], ap, 6'h00, t[1:0], 2'h2};
   endfunction
   function exp_ab(input apx, input [1:0] ap, input us, input wr);
      case ({apx, ap})
         3'h1: exp_ab = us;
         3'h2: exp_ab = us & wr;
         3'h3: exp_ab = 1'b0;
         3'h5: exp_ab = us | wr;
         3'h6, 3'h7: exp_ab = wr;
         default: exp_ab = 1'b1;
      endcase
   endfunction
   function [31:0] epa(input [1:0] s, input [31:0] b, input [31:0] v);
      case (s)
         `MMU_SZ_16M: epa = {b[31:24], v[23:0]};
         `MMU_SZ_1M: epa = {b[31:20], v[19:0]};
         `MMU_SZ_64K: epa = {b[31:16], v[15:0]};
         default: epa = {b[31:12], v[11:0]};
      endcase
   endfunction

   // ****************
   // main sequence
   // ****************
   initial begin
      seed = 22;
      n_errors = 0;
      checked = 0;
      {presetn, psel, penable, pwrite, i_req, i_user, d_req, d_write, d_user, slow} = 10'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      i_va = 32'h0;
      d_va = 32'h0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, `MMU_OFF_CTRL, 32'h0);
      chk("ctrl", 32'h0, rd);
      apb(1'b1, `MMU_OFF_STATUS, 32'hFFFFFFFF);
      apb(1'b0, `MMU_OFF_STATUS, 32'h0);
      chk("status", 32'h0, rd);
      apb(1'b0, 8'h20, 32'h0);
      chk("unmap", 32'h1, {31'h0, er});
      chk("unmapd", 32'h0, rd);
      apb(1'b1, `MMU_OFF_TAG, 32'hFFFFFFFF);
      apb(1'b0, `MMU_OFF_TAG, 32'h0);
      chk("tag", 32'h000000FF, rd);
      for (i = 0; i < 8; i = i + 1) begin
         va = $random(seed);
         xl(i[0], va, 1'b1, i[1]);
         chk_rsp(1'b0, va, 3'h0, 1'b0);
      end
      walks_is(0);
      apb(1'b1, `MMU_OFF_TBASE, 32'h00004000);
      apb(1'b1, `MMU_OFF_DOMAIN, 32'h55555555);
      apb(1'b1, `MMU_OFF_TAG, 32'h5);
      apb(1'b1, `MMU_OFF_CTRL, 32'h1);
      for (i = 0; i < 8; i = i + 1) begin
         pa = $random(seed);
         sz = (i == 7) ? `MMU_SZ_16M : `MMU_SZ_1M;
         put(13'h1100 + i[12:0], sec(pa[31:20], i[2], i[1:0], 1'b0, pa[3], pa[2:0])
             | ((i == 7) ? 32'h00040000 : 32'h0));
         for (j = 0; j < 4; j = j + 1) begin
            va = $random(seed);
            dp = $random(seed);
            va = {12'h100 + i[11:0], va[19:17], 5'h00, va[11:0]};
            xl(dp, va, j[0], j[1]);
            chk_rsp(exp_ab(i[2], i[1:0], j[1], j[0] & dp), epa(sz, pa, va),
                    pa[2:0], pa[3]);
         end
      end
      walks_is(8);
      pa = $random(seed);
      pb = $random(seed);
      apq = $random(seed) & 8'h3F;
      put(13'h1200, 32'h00000421);
      put(13'h0100, {pa[31:12], apq, pa[3:2], 2'h2});
      for (j = 16; j < 32; j = j + 1)
         put(13'h0100 + j[12:0], {pb[31:16], 4'h0, apq, pb[3:2], 2'h1});
      for (i = 0; i < 32; i = i + 1) begin
         va = $random(seed);
         dp = $random(seed);
         va = i[4] ? {12'h200, 4'h1, i[1:0], va[13:0]} : {12'h200, 8'h00, i[1:0], va[9:0]};
         xl(dp, va, i[3], i[2]);
         chk_rsp(exp_ab(1'b0, apq[2*i[1:0] +: 2], i[2], i[3] & dp),
                 epa(i[4] ? `MMU_SZ_64K : `MMU_SZ_4K, i[4] ? pb : pa, va),
                 {1'b0, i[4] ? pb[3:2] : pa[3:2]}, 1'b0);
      end
      apb(1'b1, `MMU_OFF_DOMAIN, 32'h55555551);
      xl(1'b1, 32'h20000010, 1'b0, 1'b0);
      chk_rsp(1'b1, 32'h0, 3'h0, 1'b0);
      cause_is(`MMU_C_DOM, 32'h20000010);
      apb(1'b1, `MMU_OFF_DOMAIN, 32'h5555555D);
      xl(1'b1, 32'h20000C20, 1'b1, 1'b1);
      chk_rsp(1'b0, {pa[31:12], 12'hC20}, {1'b0, pa[3:2]}, 1'b0);
      apb(1'b1, `MMU_OFF_DOMAIN, 32'h55555555);
      xl(1'b1, 32'h20000C20, 1'b0, 1'b1);
      cause_is(`MMU_C_PERM, 32'h20000C20);
      xl(1'b0, 32'h30012345, 1'b0, 1'b0);
      cause_is(`MMU_C_XLAT, 32'h30012345);
      apb(1'b0, `MMU_OFF_STATUS, 32'h0);
      ew = rd[31:16];
      put(13'h1400, sec(12'h444, 1'b0, 2'h3, 1'b1, 1'b0, 3'h0));
      for (j = 0; j < 4; j = j + 1) begin
         if (j == 3) apb(1'b1, `MMU_OFF_CTRL, 32'h3);
         apb(1'b1, `MMU_OFF_TAG, (j == 1) ? 32'h6 : ((j == 3) ? 32'h7 : 32'h5));
         xl(1'b1, 32'h40000ABC, 1'b0, 1'b0);
         ew = ew + ((j < 2) ? 1 : 0);
         walks_is(ew);
      end
      apb(1'b1, `MMU_OFF_CTRL, 32'h1);
      apb(1'b1, `MMU_OFF_FLUSH, 32'h1);
      for (j = 0; j < 3; j = j + 1)
         put(13'h1500 + j[12:0], sec(12'hA00, 1'b0, 2'h3, 1'b0, 1'b0, 3'h0));
      for (j = 0; j < 5; j = j + 1) begin
         xl(1'b1, {12'h500 + ((j == 3) ? 12'h1 : ((j == 4) ? 12'h0 : j[11:0])), 20'h00123},
            1'b0, 1'b0);
         ew = ew + ((j == 3) ? 0 : 1);
      end
      walks_is(ew);
      put(13'h1600, sec(12'hB00, 1'b0, 2'h3, 1'b0, 1'b0, 3'h0));
      apb(1'b1, `MMU_OFF_LOCK, 32'h0000000B);
      xl(1'b1, 32'h60000456, 1'b0, 1'b0);
      apb(1'b1, `MMU_OFF_LOCK, 32'h0);
      apb(1'b1, `MMU_OFF_FLUSH, 32'h1);
      xl(1'b0, 32'h60000456, 1'b0, 1'b0);
      chk_rsp(1'b0, 32'hB0000456, 3'h0, 1'b0);
      walks_is(ew + 1);
      apb(1'b1, `MMU_OFF_FLUSH, 32'h2);
      xl(1'b1, 32'h60000456, 1'b0, 1'b0);
      walks_is(ew + 2);
      apb(1'b1, `MMU_OFF_CTRL, 32'h0);
      xl(1'b0, 32'h60000456, 1'b0, 1'b1);
      chk_rsp(1'b0, 32'h60000456, 3'h0, 1'b0);
      tally_and_finish;
   end
endmodule
